// ==== common/fdc_link_if.sv ====
// byte link between host end and controller end
`timescale 1ns/1ns
`default_nettype none
interface fdc_link_if (
    input wire logic clock
);
    logic [7:0] wr_byte;
    logic wr_strobe;
    logic rd_strobe;
    logic [7:0] rd_byte;
    logic host_request_flag;
    logic transfer_direction_flag;
    logic dma_request;
    logic [1:0] rate_sel;
    logic soft_reset;

    modport device (
        input wr_byte, wr_strobe, rd_strobe, rate_sel, soft_reset,
        output rd_byte, host_request_flag, transfer_direction_flag, dma_request
    );
    modport host (
        output wr_byte, wr_strobe, rd_strobe, rate_sel, soft_reset,
        input rd_byte, host_request_flag, transfer_direction_flag, dma_request
    );
endinterface
`default_nettype wire

// ==== common/fdc_pkg.sv ====
// shared constants of the floppy controller link and its host end
package fdc_pkg;
    localparam int CLK_HZ = 100_000_000;
    // fifo
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    // command opcodes
    localparam logic [4:0] OP_READ = 5'h06;
    localparam logic [4:0] OP_WRITE = 5'h05;
    localparam logic [7:0] OP_SPECIFY = 8'h03;
    localparam logic [7:0] OP_CONFIGURE = 8'h13;
    localparam logic [7:0] OP_PERP = 8'h12;
    localparam logic [6:0] OP_LOCK = 7'h14;
    // parameter byte counts, opcode included
    localparam logic [3:0] LEN_RW = 4'h9;
    localparam logic [3:0] LEN_SPECIFY = 4'h3;
    localparam logic [3:0] LEN_CONFIGURE = 4'h4;
    localparam logic [3:0] LEN_PERP = 4'h2;
    localparam logic [3:0] LEN_LOCK = 4'h1;
    localparam logic [2:0] RES_LEN_RW = 3'h7;
    // status byte values
    localparam logic [7:0] ST0_INVALID = 8'h80;
    localparam logic [7:0] ST0_ABNORMAL = 8'h40;
    localparam logic [7:0] ST1_OVERRUN = 8'h10;
    // field positions
    localparam int CFG_FIFO_EN_BIT = 5;
    localparam int SPEC_NONDMA_BIT = 0;
    localparam int LOCK_BIT = 7;
    // bit cell lengths in clock cycles per rate code
    localparam logic [8:0] CELL_500K = 9'(CLK_HZ / 500_000);
    localparam logic [8:0] CELL_300K = 9'(CLK_HZ / 300_000);
    localparam logic [8:0] CELL_2M = 9'(CLK_HZ / 2_000_000);
    localparam logic [8:0] CELL_1M = 9'(CLK_HZ / 1_000_000);
    localparam logic [8:0] WRITE_PULSE_CYC = 9'h00A;
    localparam logic [2:0] LOCK_PULSES = 3'h4;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    // host register word offsets
    localparam logic [3:0] REG_TX_DATA = 4'h0;
    localparam logic [3:0] REG_RX_DATA = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_CTRL = 4'h3;
    localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
endpackage

// ==== design/fdc_device_end.sv ====
// floppy controller core: command phases, fifo, data separator, write path
//
// Contract
// R1 - sixteen byte fifo, software threshold
// R2 - all bytes paced by request and direction
// R3 - fifo disabled after every reset except a soft reset with lock set, which keeps fifo_en
// R4 - host services request within threshold latency
// R5 - parameters bypass fifo, host obeys flags
// R6 - flush fifo entering execution
// R7 - overrun or underrun ends the command
// R8 - underrun pads sector with zeros, crc
// R9 - host drains fifo after early read end
// R10 - specify selects dma; dma request during transfer
// R11 - separator runs up to 2 Mbit/s
// R12 - window samples data and clock halves
// R13 - pulse synced, corrected, speed integrated
// R14 - precompensation shifts pattern bits early/late
// R15 - one command selects perpendicular mode
// R16 - software sets 1 Mbps for perpendicular
// R17 - command, execution, result phases per command
// R18 - lock keeps fifo and precomp settings
// R19 - opcode flag bits and drive byte layout
// R20 - read parameters in fixed order
// R21 - seven result bytes after read
// R22 - size code sets bytes per sector
// R23 - dma request at fifo threshold
// R24 - request only when path ready; direction
`timescale 1ns/1ns
`default_nettype none
module fdc_device_end (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // host link
    fdc_link_if.device link,
    // drive side
    input wire logic read_pulse_pin,
    output logic write_pulse,
    output logic write_gate,
    output logic precomp_early,
    output logic precomp_late,
    output logic read_window_strobe,
    output logic separated_read_strobe,
    output logic [1:0] drive_sel,
    output logic head_sel,
    output logic perpendicular_mode
);
    import fdc_pkg::*;

    typedef enum logic [2:0] {
        PH_CMD = 3'b000,
        PH_EXEC_RD = 3'b001,
        PH_EXEC_WR = 3'b010,
        PH_DRAIN = 3'b011,
        PH_RESULT = 3'b100
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [8:0][7:0] prm;
        logic [3:0] prm_cnt;
        logic [3:0] prm_need;
        logic [2:0] res_idx;
        logic [2:0] res_len;
        logic [15:0][7:0] mem;
        logic [3:0] rd_ptr;
        logic [3:0] wr_ptr;
        logic [4:0] count;
        logic fifo_en;
        logic [3:0] thr;
        logic [7:0] ptrk;
        logic locked;
        logic dma_mode;
        logic perp;
        logic [7:0] st0;
        logic [7:0] st1;
        logic [14:0] byte_cnt;
        logic [7:0] sector;
        logic sy1;
        logic sy2;
        logic sy3;
        logic [8:0] period;
        logic [8:0] cnt;
        logic [2:0] lock_cnt;
        logic data_hit;
        logic clk_hit;
        logic [7:0] dsr;
        logic [7:0] csr;
        logic [2:0] bit_cnt;
        logic srs;
        logic win;
        logic [7:0] wsr;
        logic [2:0] wbit;
        logic prev_bit;
        logic underrun;
        logic [1:0] crc_left;
        logic [15:0] crc;
        logic wp;
        logic early;
        logic late;
        logic [7:0] rdb;
    } state_t;

    state_t q;
    state_t n;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    logic [8:0] nominal;
    logic [4:0] cap;
    logic [4:0] thr_eff;
    logic [14:0] sec_size;
    logic [8:0] center;
    logic cell_end;
    logic pulse;
    logic [7:0] wload;
    logic [7:0] res_byte;

    always_comb begin
        case (link.rate_sel)
            2'h0: nominal = CELL_500K;
            2'h1: nominal = CELL_300K;
            2'h2: nominal = CELL_2M; // R11
            default: nominal = CELL_1M;
        endcase
        cap = q.fifo_en ? FIFO_DEPTH : 5'h01; // R1 R3
        thr_eff = q.fifo_en ? 5'({1'b0, q.thr} + 5'h01) : 5'h01;
        sec_size = (q.prm[5] == 8'h00) ? {7'h00, q.prm[8]}
                 : 15'(15'h0080 << q.prm[5][2:0]); // R22
        case (q.res_idx)
            3'h0: res_byte = q.st0;
            3'h1: res_byte = q.st1;
            3'h2: res_byte = 8'h00;
            3'h3: res_byte = q.prm[2];
            3'h4: res_byte = q.prm[3];
            3'h5: res_byte = q.sector;
            default: res_byte = q.prm[5];
        endcase // R21
        if (q.res_len == 3'h1) begin
            res_byte = q.st0;
        end
    end

    // request and direction flags
    always_comb begin
        link.transfer_direction_flag = (q.phase == PH_EXEC_RD) || (q.phase == PH_DRAIN)
                                     || (q.phase == PH_RESULT); // R24
        case (q.phase)
            PH_CMD: link.host_request_flag = 1'b1; // R5
            PH_EXEC_RD, PH_DRAIN: link.host_request_flag = q.count != 5'h00; // R2 R24
            PH_EXEC_WR: link.host_request_flag = !q.underrun && q.crc_left == 2'h0
                                              && q.count < cap; // R24
            PH_RESULT: link.host_request_flag = 1'b1;
            default: link.host_request_flag = 1'b0;
        endcase
        link.dma_request = 1'b0;
        if (q.dma_mode && q.phase == PH_EXEC_RD) begin
            link.dma_request = q.count >= thr_eff; // R10 R23
        end else if (q.dma_mode && q.phase == PH_DRAIN) begin
            link.dma_request = q.count != 5'h00;
        end else if (q.dma_mode && q.phase == PH_EXEC_WR) begin
            link.dma_request = link.host_request_flag && q.count <= cap - thr_eff; // R23
        end
    end

    always_comb begin
        n = q;
        wload = 8'h00;
        n.srs = 1'b0;
        // ====================================================================
        // separator
        n.sy1 = read_pulse_pin;
        n.sy2 = q.sy1;
        n.sy3 = q.sy2;
        pulse = q.sy2 && !q.sy3; // R13
        cell_end = q.cnt >= q.period - 9'h001;
        n.cnt = cell_end ? 9'h000 : q.cnt + 9'h001;
        n.win = n.cnt >= {1'b0, q.period[8:1]}; // R12
        center = q.win ? 9'(q.period - {2'b00, q.period[8:2]}) : {2'b00, q.period[8:2]};
        if (q.phase != PH_EXEC_RD) begin
            n.period = nominal;
            n.lock_cnt = 3'h0;
            n.bit_cnt = 3'h0;
        end else if (pulse) begin
            n.srs = 1'b1; // R13
            if (q.win) n.data_hit = 1'b1; else n.clk_hit = 1'b1; // R12
            n.cnt = center; // R13
            if (q.cnt > center && q.period < nominal + {3'h0, nominal[8:3]}) begin
                n.period = q.period + 9'h001; // R13
            end else if (q.cnt < center && q.period > nominal - {3'h0, nominal[8:3]}) begin
                n.period = q.period - 9'h001;
            end
            if (q.lock_cnt != LOCK_PULSES) n.lock_cnt = q.lock_cnt + 3'h1;
        end
        if (cell_end) begin
            n.dsr = {q.dsr[6:0], q.data_hit}; // R12
            n.csr = {q.csr[6:0], q.clk_hit};
            n.data_hit = 1'b0;
            n.clk_hit = 1'b0;
            if (q.lock_cnt == LOCK_PULSES) n.bit_cnt = q.bit_cnt + 3'h1;
        end
        // ====================================================================
        // host byte link
        if (link.wr_strobe && q.phase == PH_CMD) begin
            n.prm[q.prm_cnt] = link.wr_byte; // R5
            n.prm_cnt = q.prm_cnt + 4'h1;
            if (q.prm_cnt == 4'h0) begin
                if (link.wr_byte[4:0] == OP_READ || link.wr_byte[4:0] == OP_WRITE) n.prm_need = LEN_RW; // R19
                else if (link.wr_byte == OP_SPECIFY) n.prm_need = LEN_SPECIFY;
                else if (link.wr_byte == OP_CONFIGURE) n.prm_need = LEN_CONFIGURE;
                else if (link.wr_byte == OP_PERP) n.prm_need = LEN_PERP;
                else if (link.wr_byte[6:0] == OP_LOCK) n.prm_need = LEN_LOCK;
                else n.prm_need = 4'h0;
            end
        end
        if (q.phase == PH_CMD && q.prm_cnt != 4'h0 && q.prm_cnt >= q.prm_need) begin
            n.prm_cnt = 4'h0;
            n.res_idx = 3'h0;
            if (q.prm_need == LEN_RW) begin
                n.phase = (q.prm[0][4:0] == OP_READ) ? PH_EXEC_RD : PH_EXEC_WR; // R17 R20
                n.count = 5'h00; // R6
                n.rd_ptr = 4'h0;
                n.wr_ptr = 4'h0;
                n.st0 = {5'h00, q.prm[1][2:0]};
                n.st1 = 8'h00;
                n.sector = q.prm[4];
                n.byte_cnt = sec_size;
                n.underrun = 1'b0;
                n.crc_left = 2'h0;
                n.crc = CRC_INIT;
                n.wbit = 3'h7;
            end else if (q.prm_need == LEN_SPECIFY) begin
                n.dma_mode = !q.prm[2][SPEC_NONDMA_BIT]; // R10
            end else if (q.prm_need == LEN_CONFIGURE) begin
                n.fifo_en = q.prm[2][CFG_FIFO_EN_BIT]; // R1 R3
                n.thr = q.prm[2][3:0];
                n.ptrk = q.prm[3];
            end else if (q.prm_need == LEN_PERP) begin
                n.perp = q.prm[1][1:0] != 2'h0; // R15
            end else begin
                n.phase = PH_RESULT;
                n.res_len = 3'h1;
                if (q.prm_need == LEN_LOCK) begin
                    n.locked = q.prm[0][LOCK_BIT]; // R18
                    n.st0 = {3'h0, q.prm[0][LOCK_BIT], 4'h0};
                end else begin
                    n.st0 = ST0_INVALID;
                end
            end
        end
        if (link.rd_strobe && q.phase == PH_RESULT) begin
            n.res_idx = q.res_idx + 3'h1; // R17
            if (q.res_idx == q.res_len - 3'h1) n.phase = PH_CMD;
        end
        if (link.rd_strobe && link.host_request_flag && q.phase != PH_RESULT
            && link.transfer_direction_flag) begin
            n.rd_ptr = q.rd_ptr + 4'h1; // R2
            n.count = q.count - 5'h01;
        end
        if (link.wr_strobe && link.host_request_flag && q.phase == PH_EXEC_WR) begin
            n.mem[q.wr_ptr] = link.wr_byte; // R2
            n.wr_ptr = q.wr_ptr + 4'h1;
            n.count = q.count + 5'h01;
        end
        // ====================================================================
        // read execution
        if (q.phase == PH_EXEC_RD && cell_end && q.lock_cnt == LOCK_PULSES
            && q.bit_cnt == 3'h7) begin
            if (n.count >= cap) begin
                n.st0 = q.st0 | ST0_ABNORMAL; // R7
                n.st1 = ST1_OVERRUN;
                n.phase = PH_DRAIN;
            end else begin
                n.mem[q.wr_ptr] = {q.dsr[6:0], q.data_hit}; // R12
                n.wr_ptr = q.wr_ptr + 4'h1;
                n.count = n.count + 5'h01;
                n.byte_cnt = q.byte_cnt - 15'h0001;
                if (q.byte_cnt == 15'h0001) begin
                    n.byte_cnt = sec_size;
                    n.sector = q.sector + 8'h01;
                    if (q.sector == q.prm[6]) begin
                        n.sector = q.sector;
                        n.phase = PH_DRAIN;
                    end
                end
            end
        end
        if (q.phase == PH_DRAIN && q.count == 5'h00) begin
            n.phase = PH_RESULT; // R9
            n.res_len = RES_LEN_RW;
        end
        // ====================================================================
        // write execution
        if (q.phase == PH_EXEC_WR && cell_end) begin
            n.wsr = {q.wsr[6:0], 1'b0};
            n.prev_bit = q.wsr[7];
            n.wbit = q.wbit + 3'h1;
            if (q.wbit == 3'h7) begin
                if (q.crc_left != 2'h0) begin
                    wload = (q.crc_left == 2'h2) ? q.crc[15:8] : q.crc[7:0];
                    n.crc_left = q.crc_left - 2'h1;
                    if (q.crc_left == 2'h1) begin
                        n.crc = CRC_INIT;
                        n.byte_cnt = sec_size;
                        n.sector = q.sector + 8'h01;
                        if (q.underrun || q.sector == q.prm[6]) begin
                            n.sector = q.sector;
                            n.phase = PH_RESULT; // R7
                            n.res_len = RES_LEN_RW;
                        end
                    end
                end else begin
                    if (q.underrun || n.count == 5'h00) begin
                        wload = 8'h00; // R8
                        n.underrun = 1'b1;
                        n.st0 = q.st0 | ST0_ABNORMAL; // R7
                        n.st1 = ST1_OVERRUN;
                    end else begin
                        wload = q.mem[q.rd_ptr];
                        n.rd_ptr = n.rd_ptr + 4'h1;
                        n.count = n.count - 5'h01;
                    end
                    n.crc = crc_byte(q.crc, wload); // R8
                    n.byte_cnt = q.byte_cnt - 15'h0001;
                    if (q.byte_cnt == 15'h0001) n.crc_left = 2'h2;
                end
                n.wsr = wload;
            end
        end
        n.wp = q.phase == PH_EXEC_WR && q.wsr[7] && q.cnt < WRITE_PULSE_CYC;
        n.early = n.wp && q.prm[2] >= q.ptrk && q.prev_bit && !q.wsr[6]; // R14
        n.late = n.wp && q.prm[2] >= q.ptrk && !q.prev_bit && q.wsr[6]; // R14
        n.rdb = (n.phase == PH_RESULT) ? res_byte : n.mem[n.rd_ptr];
        if (link.soft_reset) begin
            n = '0; // R3
            n.locked = q.locked;
            if (q.locked) begin
                n.fifo_en = q.fifo_en; // R18
                n.thr = q.thr;
                n.ptrk = q.ptrk;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0; // R3
        end else begin
            q <= n;
        end
    end

    assign link.rd_byte = q.rdb;
    assign write_pulse = q.wp;
    assign write_gate = q.phase == PH_EXEC_WR;
    assign precomp_early = q.early;
    assign precomp_late = q.late;
    assign read_window_strobe = q.win;
    assign separated_read_strobe = q.srs;
    assign drive_sel = q.prm[1][1:0];
    assign head_sel = q.prm[1][2];
    assign perpendicular_mode = q.perp;
endmodule
`default_nettype wire

// ==== design/fdc_host_end.sv ====
// host end: ahb-lite registers that drive the controller byte link
`timescale 1ns/1ns
`default_nettype none
module fdc_host_end (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // controller link
    fdc_link_if.host link
);
    import fdc_pkg::*;

    typedef struct packed {
        logic ap_valid;
        logic ap_write;
        logic [3:0] ap_idx;
        logic [7:0] tx_byte;
        logic tx_pend;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic rx_pend;
        logic [1:0] rate;
        logic srst;
        logic wr_strobe;
        logic rd_strobe;
        logic [31:0] rdata;
    } host_state_t;

    host_state_t q;
    host_state_t n;
    logic idle_link;

    always_comb begin
        n = q;
        n.wr_strobe = 1'b0;
        n.rd_strobe = 1'b0;
        // ====================================================================
        // data phase of a write
        if (q.ap_valid && q.ap_write) begin
            case (q.ap_idx)
                REG_TX_DATA: begin
                    if (!q.tx_pend) begin
                        n.tx_byte = hwdata[7:0];
                        n.tx_pend = 1'b1;
                    end
                end
                REG_RX_DATA: n.rx_pend = 1'b1;
                REG_CTRL: begin
                    n.rate = hwdata[1:0];
                    n.srst = hwdata[2];
                end
                default: n.rx_pend = n.rx_pend;
            endcase
        end
        // ====================================================================
        // link pacing, one strobe then one quiet cycle
        idle_link = !q.wr_strobe && !q.rd_strobe && !q.srst;
        if (idle_link && q.tx_pend && link.host_request_flag
            && !link.transfer_direction_flag) begin
            n.wr_strobe = 1'b1; // R5 R2
            n.tx_pend = 1'b0;
        end else if (idle_link && q.rx_pend && !q.rx_valid && link.host_request_flag
            && link.transfer_direction_flag) begin
            n.rd_strobe = 1'b1; // R2 R9
            n.rx_byte = link.rd_byte;
            n.rx_valid = 1'b1;
            n.rx_pend = 1'b0;
        end
        // ====================================================================
        // address phase
        n.ap_valid = hsel && htrans[1] && hready;
        n.ap_write = hwrite;
        n.ap_idx = haddr[5:2];
        if (!n.ap_valid || hwrite) begin
            n.rdata = 32'h0000_0000;
        end else begin
            case (haddr[5:2])
                REG_TX_DATA: n.rdata = {24'h00_0000, n.tx_byte};
                REG_RX_DATA: begin
                    n.rdata = {24'h00_0000, n.rx_byte};
                    n.rx_valid = 1'b0;
                end
                REG_STATUS: n.rdata = {26'h000_0000, n.rx_pend, n.rx_valid, n.tx_pend,
                                       link.dma_request, link.transfer_direction_flag,
                                       link.host_request_flag};
                REG_CTRL: n.rdata = {29'h0000_0000, n.srst, n.rate};
                default: n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            q <= '0;
            q.rate <= CTRL_RESET_VAL;
        end else begin
            q <= n;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign link.wr_byte = q.tx_byte;
    assign link.wr_strobe = q.wr_strobe;
    assign link.rd_strobe = q.rd_strobe;
    assign link.rate_sel = q.rate;
    assign link.soft_reset = q.srst;
endmodule
`default_nettype wire

// ==== test/fdc_link_sva.sv ====
// assertions on the byte link between host end and controller end
`timescale 1ns/1ns
`default_nettype none
module fdc_link_sva (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic host_request_flag,
    input wire logic transfer_direction_flag,
    input wire logic dma_request,
    input wire logic soft_reset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========
    // strobes
    a_wr_pulse_gap: assert property (wr_strobe |=> !(wr_strobe || rd_strobe))
        else $error("write strobe not followed by a quiet cycle");
    a_rd_pulse_gap: assert property (rd_strobe |=> !(wr_strobe || rd_strobe))
        else $error("read strobe not followed by a quiet cycle");
    a_strobe_exclusive: assert property (!(wr_strobe && rd_strobe))
        else $error("both strobes high");
    a_wr_when_ready: assert property (wr_strobe |-> host_request_flag && !transfer_direction_flag)
        else $error("write strobe against the flags");
    a_rd_when_ready: assert property (rd_strobe |-> host_request_flag && transfer_direction_flag)
        else $error("read strobe against the flags");
    // ==========
    // reset and dma
    a_reset_idle: assert property ($fell(rst) |-> host_request_flag && !transfer_direction_flag && !dma_request)
        else $error("flags wrong after reset");
    a_soft_reset_idle: assert property (soft_reset ##1 soft_reset |-> host_request_flag && !dma_request)
        else $error("flags wrong in soft reset");
    a_dma_has_byte: assert property (dma_request |-> host_request_flag)
        else $error("dma request while path not ready");
endmodule
`default_nettype wire

// ==== test/floppy_disk_controller_core_tb.sv ====
// bench for host end and controller end joined by the byte link
`timescale 1ns/1ns
`default_nettype none
module floppy_disk_controller_core_tb;
    import fdc_pkg::*;
    logic clock = 0, rst = 1, hsel = 0, hwrite = 0, read_pulse_pin = 0, pulse_on = 0;
    logic [31:0] haddr = 0, hwdata = 0, r;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    wire logic hreadyout, hresp, write_pulse, write_gate, p_early, p_late, rws, srs, head_sel, perp;
    wire logic [31:0] hrdata;
    wire logic [1:0] drive_sel;
    logic dma_seen = 0, sep_seen = 0;
    logic [7:0] res [8];
    int failures = 0, comparisons = 0, cyc = 0, pc = 0;
    always #5 clock = ~clock;
    fdc_link_if link (.clock(clock));
    fdc_host_end fdc_host_end_inst (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link));
    fdc_device_end fdc_device_end_inst (.clock(clock), .rst(rst), .link(link),
        .read_pulse_pin(read_pulse_pin), .write_pulse(write_pulse), .write_gate(write_gate),
        .precomp_early(p_early), .precomp_late(p_late), .read_window_strobe(rws),
        .separated_read_strobe(srs), .drive_sel(drive_sel), .head_sel(head_sel),
        .perpendicular_mode(perp));
    fdc_link_sva fdc_link_sva_inst (.clock(clock), .rst(rst), .wr_strobe(link.wr_strobe),
        .rd_strobe(link.rd_strobe), .host_request_flag(link.host_request_flag),
        .transfer_direction_flag(link.transfer_direction_flag),
        .dma_request(link.dma_request), .soft_reset(link.soft_reset));
    // ==========
    // drive pulses, one per 2 Mbit/s cell
    always @(posedge clock) begin
        pc <= (pc == 49) ? 0 : pc + 1;
        read_pulse_pin <= pulse_on && pc < 5;
        if (link.dma_request === 1'b1) dma_seen <= 1;
        if (srs === 1'b1) sep_seen <= 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            close_out;
        end
    end
    // ==========
    // tasks
    task close_out;
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        ahb(1'b0, 32'h8, 32'h0, r);
        while ((r & m) !== v && n < 500) begin
            ahb(1'b0, 32'h8, 32'h0, r);
            n++;
        end
        chk("status poll", v, r & m);
    endtask
    task send(input logic [7:0] b);
        ahb(1'b1, 32'h0, {24'h0, b}, r);
        poll(32'h8, 32'h0);
    endtask
    task recv(output logic [7:0] b);
        ahb(1'b1, 32'h4, 32'h0, r);
        poll(32'h10, 32'h10);
        ahb(1'b0, 32'h4, 32'h0, r);
        b = r[7:0];
    endtask
    // ==========
    // tests
    initial begin
        repeat (10) @(posedge clock);
        rst <= 0;
        ahb(1'b0, 32'h8, 32'h0, r);
        chk("status", 32'h1, r);
        ahb(1'b0, 32'hC, 32'h0, r);
        chk("ctrl", 32'h0, r);
        ahb(1'b1, 32'h10, 32'hFF, r);
        ahb(1'b0, 32'h10, 32'h0, r);
        chk("unmapped", 32'h0, r);
        $display("test reset done");
        send(8'h0A);
        recv(res[0]);
        chk("invalid st0", {24'h0, ST0_INVALID}, {24'h0, res[0]});
        poll(32'h3F, 32'h1);
        $display("test invalid done");
        ahb(1'b1, 32'hC, 32'h3, r);
        send(OP_PERP);
        send(8'h03);
        repeat (2) @(posedge clock);
        chk("perp on", 32'h1, {31'h0, perp});
        ahb(1'b1, 32'hC, 32'h4, r);
        ahb(1'b1, 32'hC, 32'h0, r);
        chk("perp after soft reset", 32'h0, {31'h0, perp});
        $display("test perpendicular done");
        ahb(1'b1, 32'hC, 32'h2, r);
        send(OP_SPECIFY);
        send(8'h00);
        send(8'h00);
        send(8'h46);
        send(8'h05);
        send(8'h02);
        send(8'h01);
        send(8'h03);
        send(8'h00);
        send(8'h03);
        send(8'h1B);
        send(8'hFF);
        chk("head and drive", 32'h5, {29'h0, head_sel, drive_sel});
        pulse_on <= 1;
        repeat (3000) @(posedge clock);
        pulse_on <= 0;
        chk("dma seen", 32'h1, {31'h0, dma_seen});
        chk("separator strobe", 32'h1, {31'h0, sep_seen});
        poll(32'h3, 32'h3);
        for (int i = 0; i < 8; i++) recv(res[i]);
        chk("st0", 32'h40, {24'h0, res[1] & 8'hC0});
        chk("st1", {24'h0, ST1_OVERRUN}, {24'h0, res[2]});
        chk("st2", 32'h0, {24'h0, res[3]});
        chk("chrn", 32'h02010300, {res[4], res[5], res[6], res[7]});
        poll(32'h3F, 32'h1);
        $display("test read overrun done");
        close_out;
    end
endmodule
`default_nettype wire
